// ### hdl/pma_pkg.sv
// Constants, types and register map of the programming model block.
// Assumes an AXI4-Lite master and a byte-wide memory port on mclk.
package pma_pkg;
   // ------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_ACC  = 8'h00;
   localparam logic [7:0] ADDR_NINE_BIT_INDEXED_MODE = 8'h04;
   localparam logic [7:0] ADDR_SIXTEEN_BIT_INDEXED_MODE = 8'h08;
   localparam logic [7:0] ADDR_STK  = 8'h0c;
   localparam logic [7:0] ADDR_PCNT = 8'h10;
   localparam logic [7:0] ADDR_FLAG = 8'h14;
   localparam logic [7:0] ADDR_CLO  = 8'h18;
   localparam logic [7:0] ADDR_CHI  = 8'h1c;
   localparam logic [7:0] ADDR_CTRL = 8'h20;
   localparam logic [7:0] ADDR_STAT = 8'h24;
   localparam logic [7:0] ADDR_EA   = 8'h28;
   localparam logic [7:0] ADDR_OPND = 8'h2c;
   localparam logic [7:0] ADDR_WIDE = 8'h30;
   // ------------------------------------------------------------
   // Fields and values
   // ------------------------------------------------------------
   localparam int F_S = 7;
   localparam int F_X = 6;
   localparam int F_H = 5;
   localparam int F_I = 4;
   localparam int F_N = 3;
   localparam int F_Z = 2;
   localparam int F_V = 1;
   localparam int F_C = 0;
   localparam logic [7:0] FLAG_RST = 8'hd0;
   localparam int CTL_GO   = 0;
   localparam int CTL_STOP = 1;
   localparam int CTL_WAKE = 2;
   localparam int CTL_MODE = 4;
   localparam int CTL_COND = 8;
   localparam int ST_BUSY  = 0;
   localparam int ST_DONE  = 1;
   localparam int ST_ERR   = 2;
   localparam int ST_STOPD = 3;
   localparam int ST_PAGE2 = 4;
   localparam int ST_TAKEN = 5;
   localparam logic [7:0]  PREFIX_PAGE2 = 8'h18;
   localparam logic [2:0]  QUEUE_MIN    = 3'h3;
   localparam logic [2:0]  QLEN_LO      = 3'h4;
   localparam logic [2:0]  QLEN_HI      = 3'h6;
   localparam logic [15:0] VEC_DEFAULT  = 16'hfffe;
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;
   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      MD_INH, MD_IMM8, MD_IMM16, MD_DIR, MD_EXT, MD_REL8, MD_REL16, MD_IDX
   } pma_mode_t;
   typedef enum logic [2:0] {
      S_VEC_HI, S_VEC_LO, S_IDLE, S_PTR_HI, S_PTR_LO, S_STOP
   } pma_state_t;
   typedef struct packed {
      logic        awvalid;
      logic [7:0]  awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [7:0]  araddr;
      logic        rready;
   } pma_axi_req_t;
   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } pma_axi_rsp_t;
   typedef struct packed {
      logic        req;
      logic [15:0] addr;
   } pma_mem_req_t;
   typedef struct packed {
      logic        ack;
      logic [7:0]  rdata;
   } pma_mem_rsp_t;
endpackage

// ### hdl/pma_core.sv
// Programmer register set and operand address generation.
// Assumes an AXI4-Lite master and a byte memory that acks on mclk.
`timescale 1ns/1ns
module pma_core
   import pma_pkg::*;
#(
   parameter logic [15:0] RESET_VECTOR = VEC_DEFAULT
)(
   input  wire logic         mclk,
   input  wire logic         srst,
   input  wire pma_axi_req_t axi_req,
   output pma_axi_rsp_t      axi_rsp,
   output pma_mem_req_t      mem_req,
   input  wire pma_mem_rsp_t mem_rsp,
   output logic              core_stopped
);
   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   pma_axi_rsp_t rsp_q;
   pma_mem_req_t mem_q;
   pma_state_t   state_q;
   logic [7:0]   acc_a_q, acc_b_q, flag_q, vec_hi_q;
   logic [15:0]  nine_bit_indexed_mode_q, sixteen_bit_indexed_mode_q, stk_q, pc_q;
   logic [15:0]  ea_q, opnd_q, ptr_q;
   logic [19:0]  wide_q;
   logic [47:0]  code_q;
   logic [2:0]   qcnt_q;
   logic         done_q, err_q, page2_q, taken_q, stopped_q;
   logic [7:0]   aw_q;
   logic [31:0]  wd_q;
   logic [3:0]   ws_q;
   logic         aw_hold_q, w_hold_q;
   logic         wr_en, go, commit, vec_load, ptr_done;
   logic [31:0]  wr_data, rd_word;
   logic         rd_ok, wr_ok;
   logic [7:0]   cb [6];
   logic [7:0]   o0, o1, o2, xb;
   logic         pg2, ind, wb, err, off_neg, take;
   logic [1:0]   rr;
   logic [2:0]   len;
   logic [15:0]  base, off, step, new_base, immediate_mode;
   logic [19:0]  sum20;
   pma_mode_t    mode;

   assign axi_rsp      = rsp_q;
   assign mem_req      = mem_q;
   assign core_stopped = stopped_q;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  st);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (st[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction

   // Odd codes are the negation of the even one below them
   function automatic logic cond_met(input logic [3:0] c,
                                     input logic [7:0] f);
      logic b;
      unique case (c[3:1])
         3'h0: b = 1'b1;
         3'h1: b = ~(f[F_C] | f[F_Z]);
         3'h2: b = ~f[F_C];
         3'h3: b = ~f[F_Z];
         3'h4: b = ~f[F_V];
         3'h5: b = ~f[F_N];
         3'h6: b = ~(f[F_N] ^ f[F_V]);
         3'h7: b = ~(f[F_Z] | (f[F_N] ^ f[F_V]));
      endcase
      return b ^ c[0];
   endfunction

   function automatic logic [15:0] sel_base(input logic [1:0] r,
                                            input logic [15:0] x,
                                            input logic [15:0] y,
                                            input logic [15:0] s,
                                            input logic [15:0] p);
      logic [15:0] v;
      unique case (r)
         2'h0: v = x;
         2'h1: v = y;
         2'h2: v = s;
         2'h3: v = p;
      endcase
      return v;
   endfunction

   // ------------------------------------------------------------
   // AXI4-Lite slave
   // ------------------------------------------------------------
   assign wr_en   = aw_hold_q & w_hold_q & ~rsp_q.bvalid;
   assign wr_data = wd_q;

   always_ff @(posedge mclk) begin
      if (srst) begin
         rsp_q     <= '0;
         aw_hold_q <= 1'b0;
         w_hold_q  <= 1'b0;
         aw_q      <= 8'h00;
         wd_q      <= 32'h0000_0000;
         ws_q      <= 4'h0;
      end else begin
         rsp_q.awready <= ~aw_hold_q & ~rsp_q.bvalid;
         rsp_q.wready  <= ~w_hold_q & ~rsp_q.bvalid;
         if (axi_req.awvalid && rsp_q.awready) begin
            aw_hold_q     <= 1'b1;
            aw_q          <= axi_req.awaddr;
            rsp_q.awready <= 1'b0;
         end
         if (axi_req.wvalid && rsp_q.wready) begin
            w_hold_q     <= 1'b1;
            wd_q         <= axi_req.wdata;
            ws_q         <= axi_req.wstrb;
            rsp_q.wready <= 1'b0;
         end
         if (wr_en) begin
            aw_hold_q     <= 1'b0;
            w_hold_q      <= 1'b0;
            rsp_q.bvalid  <= 1'b1;
            rsp_q.bresp   <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end
         if (rsp_q.bvalid && axi_req.bready) begin
            rsp_q.bvalid <= 1'b0;
         end
         rsp_q.arready <= ~rsp_q.rvalid & ~rsp_q.arready;
         if (axi_req.arvalid && rsp_q.arready) begin
            rsp_q.arready <= 1'b0;
            rsp_q.rvalid  <= 1'b1;
            rsp_q.rdata   <= rd_word;
            rsp_q.rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
         end
         if (rsp_q.rvalid && axi_req.rready) begin
            rsp_q.rvalid <= 1'b0;
         end
      end
   end

   always_comb begin
      rd_ok = 1'b1;
      unique case (axi_req.araddr)
         ADDR_ACC:  rd_word = {16'h0000, acc_a_q, acc_b_q};
         ADDR_NINE_BIT_INDEXED_MODE: rd_word = {16'h0000, nine_bit_indexed_mode_q};
         ADDR_SIXTEEN_BIT_INDEXED_MODE: rd_word = {16'h0000, sixteen_bit_indexed_mode_q};
         ADDR_STK:  rd_word = {16'h0000, stk_q};
         ADDR_PCNT: rd_word = {16'h0000, pc_q};
         ADDR_FLAG: rd_word = {24'h00_0000, flag_q};
         ADDR_CLO:  rd_word = code_q[31:0];
         ADDR_CHI:  rd_word = {16'h0000, code_q[47:32]};
         ADDR_STAT: rd_word = {26'h000_0000, taken_q, page2_q,
                               core_stopped, err_q, done_q,
                               state_q != S_IDLE};
         ADDR_EA:   rd_word = {16'h0000, ea_q};
         ADDR_OPND: rd_word = {16'h0000, opnd_q};
         ADDR_WIDE: rd_word = {12'h000, wide_q};
         default: begin
            rd_word = 32'h0000_0000;
            rd_ok   = 1'b0;
         end
      endcase
   end

   assign wr_ok = (aw_q <= ADDR_WIDE) && (aw_q[1:0] == 2'h0)
                  && (aw_q != ADDR_EA) && (aw_q != ADDR_OPND)
                  && (aw_q != ADDR_WIDE);

   // ------------------------------------------------------------
   // Address generation
   // ------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         cb[i] = code_q[8*i +: 8];
      end
   end

   assign mode = pma_mode_t'(wr_data[CTL_MODE +: 3]);

   always_comb begin
      pg2      = (cb[0] == PREFIX_PAGE2);
      o0       = pg2 ? cb[2] : cb[1];
      o1       = pg2 ? cb[3] : cb[2];
      o2       = pg2 ? cb[4] : cb[3];
      xb       = o0;
      len      = pg2 ? 3'h2 : 3'h1;
      base     = 16'h0000;
      off      = 16'h0000;
      off_neg  = 1'b0;
      step     = 16'h0000;
      ind      = 1'b0;
      wb       = 1'b0;
      err      = 1'b0;
      immediate_mode      = 16'h0000;
      take     = 1'b0;
      rr       = (xb[7:5] == 3'h7) ? xb[4:3] : xb[7:6];
      unique case (mode)
         MD_INH: begin
            base = pc_q;
         end
         MD_IMM8: begin
            base = pc_q;
            off  = {13'h0000, len};
            immediate_mode  = {8'h00, o0};
            len  = len + 3'h1;
         end
         MD_IMM16: begin
            base = pc_q;
            off  = {13'h0000, len};
            immediate_mode  = {o0, o1};
            len  = len + 3'h2;
         end
         MD_DIR: begin
            off = {8'h00, o0};
            len = len + 3'h1;
         end
         MD_EXT: begin
            off = {o0, o1};
            len = len + 3'h2;
         end
         MD_REL8: begin
            len     = len + 3'h1;
            base    = pc_q + {13'h0000, len};
            off     = {{8{o0[7]}}, o0};
            off_neg = o0[7];
            take    = cond_met(wr_data[CTL_COND +: 4], flag_q);
         end
         MD_REL16: begin
            len     = len + 3'h2;
            base    = pc_q + {13'h0000, len};
            off     = {o0, o1};
            off_neg = o0[7];
            take    = cond_met(wr_data[CTL_COND +: 4], flag_q);
         end
         MD_IDX: begin
            len  = len + 3'h1;
            base = sel_base(rr, nine_bit_indexed_mode_q, sixteen_bit_indexed_mode_q, stk_q, pc_q);
            if (!xb[5]) begin
               off     = {{11{xb[4]}}, xb[4:0]};
               off_neg = xb[4];
            end else if (xb[7:5] != 3'h7) begin
               // Codes 0..7 step +1..+8, codes 8..15 step -8..-1
               step = xb[3] ? {{12{1'b1}}, xb[3:0]}
                            : {12'h000, xb[3:0] + 4'h1};
               wb   = 1'b1;
               err  = (rr == 2'h3);
               if (!xb[4]) begin
                  off     = step;
                  off_neg = xb[3];
               end
            end else if (!xb[2]) begin
               if (!xb[1]) begin
                  off     = {{7{xb[0]}}, xb[0], o1};
                  off_neg = xb[0];
                  len     = len + 3'h1;
               end else begin
                  off     = {o1, o2};
                  off_neg = o1[7];
                  ind     = xb[0];
                  len     = len + 3'h2;
               end
            end else begin
               unique case (xb[1:0])
                  2'h0: off = {8'h00, acc_a_q};
                  2'h1: off = {8'h00, acc_b_q};
                  2'h2: off = {acc_a_q, acc_b_q};
                  2'h3: begin
                     off = {acc_a_q, acc_b_q};
                     ind = 1'b1;
                  end
               endcase
            end
         end
      endcase
      // Wide sum keeps carry and sign beyond the 16-bit address
      sum20    = {4'h0, base} + {{4{off_neg}}, off};
      new_base = base + step;
      if (len > qcnt_q || qcnt_q < QUEUE_MIN) begin
         err = 1'b1;
      end
   end

   assign go = wr_en && wr_ok && (aw_q == ADDR_CTRL) && ws_q[0]
               && wr_data[CTL_GO] && (state_q == S_IDLE);
   assign commit   = go && !err;
   assign vec_load = (state_q == S_VEC_LO) && mem_q.req && mem_rsp.ack;
   assign ptr_done = (state_q == S_PTR_LO) && mem_q.req && mem_rsp.ack;

   // ------------------------------------------------------------
   // Programmer registers
   // ------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (srst) begin
         acc_a_q <= 8'h00;
         acc_b_q <= 8'h00;
         nine_bit_indexed_mode_q  <= 16'h0000;
         sixteen_bit_indexed_mode_q  <= 16'h0000;
         stk_q   <= 16'h0000;
         pc_q    <= 16'h0000;
         flag_q  <= FLAG_RST;
      end else begin
         if (wr_en && wr_ok) begin
            unique case (aw_q)
               ADDR_ACC: {acc_a_q, acc_b_q} <= 16'(merge(
                  {16'h0000, acc_a_q, acc_b_q}, wr_data, ws_q));
               ADDR_NINE_BIT_INDEXED_MODE: nine_bit_indexed_mode_q <=
                  16'(merge({16'h0000, nine_bit_indexed_mode_q}, wr_data, ws_q));
               ADDR_SIXTEEN_BIT_INDEXED_MODE: sixteen_bit_indexed_mode_q <=
                  16'(merge({16'h0000, sixteen_bit_indexed_mode_q}, wr_data, ws_q));
               ADDR_STK: stk_q <=
                  16'(merge({16'h0000, stk_q}, wr_data, ws_q));
               ADDR_PCNT: pc_q <=
                  16'(merge({16'h0000, pc_q}, wr_data, ws_q));
               ADDR_FLAG: flag_q <=
                  8'(merge({24'h00_0000, flag_q}, wr_data, ws_q));
               default: ;
            endcase
         end
         if (vec_load) begin
            pc_q <= {vec_hi_q, mem_rsp.rdata};
         end
         if (commit) begin
            pc_q <= take ? sum20[15:0] : pc_q + {13'h0000, len};
            if (wb) begin
               unique case (rr)
                  2'h0: nine_bit_indexed_mode_q <= new_base;
                  2'h1: sixteen_bit_indexed_mode_q <= new_base;
                  2'h2: stk_q  <= new_base;
                  default: ;
               endcase
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Code queue, results and status
   // ------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (srst) begin
         code_q  <= 48'h0000_0000_0000;
         qcnt_q  <= 3'h0;
         ea_q    <= 16'h0000;
         opnd_q  <= 16'h0000;
         wide_q  <= 20'h0_0000;
         done_q  <= 1'b0;
         err_q   <= 1'b0;
         page2_q <= 1'b0;
         taken_q <= 1'b0;
      end else begin
         if (wr_en && wr_ok && aw_q == ADDR_CLO) begin
            code_q[31:0] <= merge(code_q[31:0], wr_data, ws_q);
            qcnt_q       <= QLEN_LO;
         end
         if (wr_en && wr_ok && aw_q == ADDR_CHI) begin
            code_q[47:32] <=
               16'(merge({16'h0000, code_q[47:32]}, wr_data, ws_q));
            qcnt_q        <= QLEN_HI;
         end
         if (wr_en && wr_ok && aw_q == ADDR_STAT) begin
            done_q <= done_q & ~wr_data[ST_DONE];
            err_q  <= err_q & ~wr_data[ST_ERR];
         end
         // Set wins over a clear in the same cycle
         if (go) begin
            qcnt_q  <= 3'h0;
            page2_q <= pg2;
            err_q   <= err_q | err;
            done_q  <= err | ~ind;
            taken_q <= take;
            // Unaligned results stand as computed
            ea_q    <= sum20[15:0];
            wide_q  <= sum20;
            opnd_q  <= immediate_mode;
         end
         if (ptr_done) begin
            ea_q   <= {ptr_q[15:8], mem_rsp.rdata};
            done_q <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // Sequencer and memory port
   // ------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (srst) begin
         state_q  <= S_VEC_HI;
         mem_q    <= '0;
         vec_hi_q <= 8'h00;
         stopped_q <= 1'b0;
         ptr_q    <= 16'h0000;
      end else begin
         unique case (state_q)
            S_VEC_HI: begin
               if (mem_q.req && mem_rsp.ack) begin
                  mem_q.req <= 1'b0;
                  vec_hi_q  <= mem_rsp.rdata;
                  state_q   <= S_VEC_LO;
               end else if (!mem_q.req) begin
                  mem_q.req  <= 1'b1;
                  mem_q.addr <= RESET_VECTOR;
               end
            end
            S_VEC_LO: begin
               if (vec_load) begin
                  mem_q.req <= 1'b0;
                  state_q   <= S_IDLE;
               end else if (!mem_q.req) begin
                  mem_q.req  <= 1'b1;
                  mem_q.addr <= RESET_VECTOR + 16'h0001;
               end
            end
            S_IDLE: begin
               if (commit && ind) begin
                  ptr_q      <= sum20[15:0];
                  mem_q.req  <= 1'b1;
                  mem_q.addr <= sum20[15:0];
                  state_q    <= S_PTR_HI;
               end else if (wr_en && wr_ok && aw_q == ADDR_CTRL
                            && wr_data[CTL_STOP] && !flag_q[F_S]) begin
                  state_q   <= S_STOP;
                  stopped_q <= 1'b1;
               end
            end
            S_PTR_HI: begin
               if (mem_q.req && mem_rsp.ack) begin
                  ptr_q[15:8] <= mem_rsp.rdata;
                  mem_q.addr  <= ptr_q + 16'h0001;
               end else if (!mem_q.req) begin
                  mem_q.req <= 1'b1;
               end
               if (mem_q.req && mem_rsp.ack) begin
                  mem_q.req <= 1'b0;
                  state_q   <= S_PTR_LO;
               end
            end
            S_PTR_LO: begin
               if (ptr_done) begin
                  mem_q.req <= 1'b0;
                  state_q   <= S_IDLE;
               end else if (!mem_q.req) begin
                  mem_q.req <= 1'b1;
               end
            end
            S_STOP: begin
               // Only an explicit wake leaves; go is ignored here
               if (wr_en && wr_ok && aw_q == ADDR_CTRL
                   && wr_data[CTL_WAKE]) begin
                  state_q   <= S_IDLE;
                  stopped_q <= 1'b0;
               end
            end
            default: begin
               state_q   <= S_IDLE;
               stopped_q <= 1'b0;
            end
         endcase
      end
   end
endmodule

// ### testbench/pma_core_sva.sv
// Port timing checks for the programming model block.
// Assumes it is bound into pma_core and sees its ports only.
`timescale 1ns/1ns
module pma_core_sva
   import pma_pkg::*;
#(
   parameter logic [15:0] RESET_VECTOR = VEC_DEFAULT
)(
   input wire logic         mclk,
   input wire logic         srst,
   input wire pma_axi_req_t axi_req,
   input wire pma_axi_rsp_t axi_rsp,
   input wire pma_mem_req_t mem_req,
   input wire pma_mem_rsp_t mem_rsp,
   input wire logic         core_stopped
);
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);
   AST_RST_CLEAR: assert property ($fell(srst) |-> !core_stopped
      && !mem_req.req && !axi_rsp.bvalid && !axi_rsp.rvalid)
      else $error("outputs not cleared by reset");
   AST_VEC_FETCH: assert property ($fell(srst) |-> ##[1:3]
      (mem_req.req && mem_req.addr == RESET_VECTOR))
      else $error("start vector not fetched");
   AST_VEC_LOW: assert property (mem_req.req && mem_rsp.ack
      && mem_req.addr == RESET_VECTOR |-> ##[1:3]
      (mem_req.req && mem_req.addr == RESET_VECTOR + 16'h0001))
      else $error("vector low byte not fetched next");
   AST_MEM_HOLD: assert property (mem_req.req && !mem_rsp.ack
      |=> mem_req.req && $stable(mem_req.addr))
      else $error("memory request dropped before ack");
   AST_MEM_DROP: assert property (mem_req.req && mem_rsp.ack
      |=> !mem_req.req)
      else $error("memory request held after ack");
   AST_B_DONE: assert property (axi_rsp.bvalid && axi_req.bready
      |=> !axi_rsp.bvalid)
      else $error("write response not retired");
   AST_R_LAT: assert property (axi_req.arvalid && axi_rsp.arready
      |=> axi_rsp.rvalid ##1 (!axi_rsp.rvalid || !axi_req.rready))
      else $error("read data not one cycle after address");
   AST_ERR_ZERO: assert property (axi_rsp.rvalid
      && axi_rsp.rresp == RESP_SLVERR |-> axi_rsp.rdata == 32'h0000_0000)
      else $error("refused read returned data");
   cover property (mem_req.req && mem_rsp.ack);
   cover property (axi_rsp.rvalid && axi_rsp.rresp == RESP_SLVERR);
   cover property ($rose(core_stopped));
endmodule
bind pma_core pma_core_sva #(.RESET_VECTOR(RESET_VECTOR)) u_sva (
   .mclk(mclk), .srst(srst), .axi_req(axi_req), .axi_rsp(axi_rsp),
   .mem_req(mem_req), .mem_rsp(mem_rsp), .core_stopped(core_stopped));

// ### testbench/pma_mem_model.sv
// Byte memory on the fetch port; contents derived from the address.
// Assumes one request at a time; answers fast and slow in turn.
`timescale 1ns/1ns
module pma_mem_model
   import pma_pkg::*;
(
   input  wire logic         mclk,
   input  wire logic         srst,
   input  wire pma_mem_req_t mem_req,
   output pma_mem_rsp_t      mem_rsp
);
   logic [1:0] cnt_q;
   logic       slow_q;
   function automatic logic [7:0] val(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h3c;
   endfunction
   // Idle data inverted each cycle so a stale byte never looks valid
   always_ff @(posedge mclk) begin
      if (srst) begin
         mem_rsp <= '0;
         cnt_q <= 2'h0;
         slow_q <= 1'b0;
      end else if (mem_req.req && !mem_rsp.ack
                   && cnt_q == {slow_q, 1'b0}) begin
         mem_rsp.ack <= 1'b1;
         mem_rsp.rdata <= val(mem_req.addr);
         cnt_q <= 2'h0;
         slow_q <= ~slow_q;
      end else begin
         mem_rsp.ack <= 1'b0;
         mem_rsp.rdata <= ~mem_rsp.rdata;
         cnt_q <= cnt_q + {1'b0, mem_req.req & ~mem_rsp.ack};
      end
   end
endmodule

// ### testbench/tb.sv
// Register-level test of the programming model block over AXI4-Lite.
// Assumes the memory model answers the core's fetch port.
`timescale 1ns/1ns
module tb
   import pma_pkg::*;
;
   logic         mclk;
   logic         srst;
   pma_axi_req_t rq;
   pma_axi_rsp_t rs;
   pma_mem_req_t mq;
   pma_mem_rsp_t ms;
   logic         stopped;
   logic [31:0]  d;
   logic [31:0]  st;
   logic [1:0]   resp;
   int           fail_count;
   int           compares;
   // Entries: code bytes, control word, expected address (X=1000 D=1234)
   logic [63:0]  tv [12] = '{
      64'h0000_aba6_0031_00ab,
      64'h0034_12a6_0041_1234,
      64'h0000_1fa6_0071_0fff,
      64'h0000_e1a6_0071_0f00,
      64'h3412_e2a6_0071_2234,
      64'h0000_e4a6_0071_1012,
      64'h0000_e6a6_0071_2234,
      64'h0000_8fa6_0071_200f,
      64'h1000_e3a6_0071_3c3d,
      64'h0000_e7a6_0071_2a2b,
      64'h00ab_a618_0031_00ab,
      64'h0000_37a6_0071_1000};
   pma_core uut (.mclk(mclk), .srst(srst), .axi_req(rq), .axi_rsp(rs),
      .mem_req(mq), .mem_rsp(ms), .core_stopped(stopped));
   pma_mem_model mdl (.mclk(mclk), .srst(srst), .mem_req(mq), .mem_rsp(ms));
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] v);
      logic pa;
      logic pw;
      @(posedge mclk);
      pa = 1'b1;
      pw = 1'b1;
      rq.awaddr <= a;
      rq.wdata <= v;
      rq.wstrb <= 4'hf;
      rq.awvalid <= 1'b1;
      rq.wvalid <= 1'b1;
      rq.bready <= 1'b1;
      while (pa || pw) begin
         @(posedge mclk);
         pa = pa && !rs.awready;
         pw = pw && !rs.wready;
         rq.awvalid <= pa;
         rq.wvalid <= pw;
      end
      while (!rs.bvalid) @(posedge mclk);
      resp = rs.bresp;
      rq.bready <= 1'b0;
   endtask
   task automatic rd(logic [7:0] a);
      @(posedge mclk);
      rq.araddr <= a;
      rq.arvalid <= 1'b1;
      rq.rready <= 1'b1;
      do @(posedge mclk); while (!rs.arready);
      rq.arvalid <= 1'b0;
      while (!rs.rvalid) @(posedge mclk);
      d = rs.rdata;
      resp = rs.rresp;
      rq.rready <= 1'b0;
   endtask
   // Run one instruction; leaves status in st, address in d
   task automatic ex(logic [31:0] c, logic [31:0] k);
      wr(ADDR_CLO, c);
      wr(ADDR_CTRL, k);
      rd(ADDR_STAT);
      for (int i = 0; i < 20 && d[ST_DONE] !== 1'b1; i++) rd(ADDR_STAT);
      st = d;
      wr(ADDR_STAT, 32'h0000_0006);
      rd(ADDR_EA);
   endtask
   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge mclk);
      fail_count++;
      report_and_stop();
   end
   initial begin
      srst = 1'b1;
      rq = '0;
      fail_count = 0;
      compares = 0;
      repeat (8) @(posedge mclk);
      srst <= 1'b0;
      rd(ADDR_STAT);
      for (int i = 0; i < 20 && d[ST_BUSY] !== 1'b0; i++) rd(ADDR_STAT);
      rd(ADDR_PCNT);
      chk("pc", {16'h0000, mdl.val(16'hfffe), mdl.val(16'hffff)},
          d);
      rd(ADDR_FLAG);
      chk("flags", {24'h00_0000, FLAG_RST}, d);
      $display("test reset done");
      ex(32'h0000_10a6, 32'h0000_0051);
      rd(ADDR_PCNT);
      chk("taken", 32'h0000_3d4e, d);
      ex(32'h0000_10a6, 32'h0000_0151);
      rd(ADDR_PCNT);
      chk("not taken", 32'h0000_3d50, d);
      ex(32'h0000_cfa6, 32'h0000_0071);
      chk("pc base", 32'h0000_3d5f, d);
      ex(32'h00e2_a618, 32'h0000_0071);
      chk("short queue", 32'h0000_0001, {31'h0, st[ST_ERR]});
      $display("test branch done");
      wr(ADDR_NINE_BIT_INDEXED_MODE, 32'h0000_1000);
      wr(ADDR_ACC, 32'h0000_1234);
      wr(ADDR_STK, 32'h0000_2000);
      rd(ADDR_ACC);
      chk("acc", 32'h0000_1234, d);
      foreach (tv[i]) begin
         ex(tv[i][63:32], {16'h0000, tv[i][31:16]});
         chk("ea", {16'h0000, tv[i][15:0]}, d);
      end
      rd(ADDR_NINE_BIT_INDEXED_MODE);
      chk("step", 32'h0000_1008, d);
      $display("test address done");
      rd(8'h40);
      chk("unmapped", {30'h0, RESP_SLVERR}, {30'h0, resp});
      wr(ADDR_EA, 32'h0000_0001);
      chk("read only", {30'h0, RESP_SLVERR}, {30'h0, resp});
      $display("test refuse done");
      wr(ADDR_CTRL, 32'h0000_0002);
      rd(ADDR_STAT);
      chk("no stop", 32'h0000_0000, {31'h0, stopped});
      wr(ADDR_FLAG, 32'h0000_0050);
      wr(ADDR_CTRL, 32'h0000_0002);
      rd(ADDR_STAT);
      chk("stop", 32'h0000_0001, {31'h0, stopped});
      wr(ADDR_CTRL, 32'h0000_0004);
      rd(ADDR_STAT);
      chk("wake", 32'h0000_0000, {31'h0, stopped});
      $display("test stop done");
      report_and_stop();
   end
endmodule
